// ==== include/apm_pkg.sv ====
/*
 * Package for the audio power-management and codec access decode block: offsets, field
 * positions, reset values, mixer range codes and the packed structs that carry requests.
 * Assumes one clock domain; the resume-well reset is a separate input of the top module.
 */
// Behaviour
// - Set the power-event status flag whenever a power event would be signalled, enable or not.
// - Writing one to the status flag clears it; writing zero leaves it unchanged.
// - The status flag lives on the resume reset, not the core reset.
// - Enable and status both set raise the audio wake flag.
// - Two-bit power state field reads back; 00 is fully on, 11 is D3hot.
// - In D3hot, configuration still answers; I/O and memory do not; interrupt blocked. The code still raises mixReady for them, with no codec access.
// - Writes of 10b or 01b to power state complete but change nothing.
// - Codec ID sent with each mixer access comes from the offset range hit.
// - Offsets 00h, 80h, 100h map to primary, secondary, tertiary ranges.
// - Every mixer access becomes one 16-bit codec register access.
// - The lowest active byte enable picks the codec word accessed.
// - No byte enables active: access first word of the containing eight-byte block.
// - Tertiary range served only through the memory window, not the I/O window.
// - Secondary ID from config bits 1:0, tertiary from 3:2; primary ID fixed.
package apm_pkg;

    // ****************************************
    // configuration registers
    // ****************************************
    localparam logic [7:0] PM_CTRL_OFFSET = 8'h54;
    localparam logic [7:0] CODEC_ID_OFFSET = 8'h40;
    localparam logic [15:0] PM_CTRL_RESET = 16'h0000;
    localparam logic [7:0] CODEC_ID_RESET = 8'h09;
    localparam int PME_STATUS_BIT = 15;
    localparam int PME_ENABLE_BIT = 8;
    localparam int PSTATE_LSB = 0;
    localparam logic [1:0] PSTATE_D0 = 2'h0;
    localparam logic [1:0] PSTATE_D3HOT = 2'h3;
    localparam int SEC_ID_LSB = 0;
    localparam int TER_ID_LSB = 2;

    // ****************************************
    // mixer window
    // ****************************************
    localparam int MIX_ADDR_W = 9;
    localparam logic [1:0] PRIMARY_CODEC_ID = 2'h0;
    localparam logic [1:0] RANGE_PRIMARY = 2'h0;
    localparam logic [1:0] RANGE_SECONDARY = 2'h1;
    localparam logic [1:0] RANGE_TERTIARY = 2'h2;
    localparam int RANGE_LSB = 7;

    typedef struct packed {
        logic [MIX_ADDR_W-1:0] addr;
        logic [3:0] byteEn;
        logic write;
        logic memSpace;
        logic [31:0] wdata;
    } apm_mix_req_t;

    typedef struct packed {
        logic [1:0] codecId;
        logic [6:0] regIndex;
        logic write;
        logic [15:0] wdata;
    } apm_codec_req_t;

endpackage : apm_pkg

// ==== src/apm_codec_bridge.sv ====
/*
 * Power-management register and mixer-window to codec register access bridge.
 * Assumes a single ref_clk at 200 MHz, core reset rstn and resume-well reset resumeRstn,
 * and a frame serializer outside that answers each codec request with codecDone.
 */
`timescale 1ns/1ps
module apm_codec_bridge
    import apm_pkg::*;
(
    input wire logic refClk,
    input wire logic rstn,
    input wire logic resumeRstn,
    // configuration space access
    input wire logic cfgValid,
    input wire logic cfgWrite,
    input wire logic [7:0] cfgAddr,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWdata,
    output logic cfgReady,
    output logic [31:0] cfgRdata,
    // power event source and outputs
    input wire logic pmeEvent,
    output logic power_event_out_n,
    output logic audio_wake_flag,
    input wire logic intIn,
    output logic intOut,
    // mixer window access
    input wire logic mixValid,
    input wire apm_mix_req_t mixReq,
    output logic mixReady,
    output logic [31:0] mixRdata,
    // codec side
    output logic codecValid,
    output apm_codec_req_t codecReq,
    input wire logic codecDone,
    input wire logic [15:0] codecRdata
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {IDLE, ISSUE, WAIT, ANSWER} apm_state_e_t;

    typedef struct packed {
        apm_state_e_t state;
        logic [1:0] pstate;
        logic pmeEnable;
        logic [7:0] codecIdCfg;
        logic [31:0] mixRdata;
        logic wordHigh;
        apm_codec_req_t codecReq;
    } apm_core_t;

    apm_core_t cur;
    apm_core_t next_cur;
    logic pmeStatus;
    logic next_pmeStatus;

    function automatic logic [1:0] first_word(input logic [3:0] be);
        if (be[0] || be[1]) begin
            return 2'h0;
        end else if (be[2] || be[3]) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction : first_word

    logic cfgHitPm;
    logic cfgHitId;
    logic inD3;
    logic [1:0] range;
    logic mixAccept;
    logic [1:0] wordSel;
    logic [15:0] wHalf;

    assign cfgHitPm = cfgAddr[7:2] == PM_CTRL_OFFSET[7:2];
    assign cfgHitId = cfgAddr[7:2] == CODEC_ID_OFFSET[7:2];
    assign inD3 = cur.pstate == PSTATE_D3HOT;
    assign range = mixReq.addr[RANGE_LSB +: 2];
    // ****************************************
    // mixer decode
    // ****************************************
    assign mixAccept = mixValid && !inD3 && range != 2'h3
        && (range != RANGE_TERTIARY || mixReq.memSpace);
    assign wordSel = first_word(mixReq.byteEn);
    assign wHalf = wordSel[0] ? mixReq.wdata[31:16] : mixReq.wdata[15:0];

    assign cfgReady = cfgValid;
    assign intOut = intIn && !inD3;
    assign power_event_out_n = !(pmeStatus && cur.pmeEnable);
    assign audio_wake_flag = pmeStatus && cur.pmeEnable;
    assign codecValid = cur.state == WAIT;
    assign codecReq = cur.codecReq;
    assign mixReady = cur.state == ANSWER || (mixValid && !mixAccept && cur.state == IDLE);
    assign mixRdata = cur.mixRdata;

    always_comb begin
        cfgRdata = 32'h0;
        if (cfgHitPm) begin
            cfgRdata[31:16] = {pmeStatus, 6'h0, cur.pmeEnable, 6'h0, cur.pstate};
        end else if (cfgHitId) begin
            cfgRdata[7:0] = cur.codecIdCfg;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_cur = cur;
        next_pmeStatus = pmeStatus;
        if (cfgValid && cfgWrite && cfgHitPm && cfgByteEn[3] && cfgWdata[31]) begin
            next_pmeStatus = 1'b0;
        end
        if (pmeEvent) begin
            next_pmeStatus = 1'b1;
        end
        if (cfgValid && cfgWrite && cfgHitPm) begin
            if (cfgByteEn[3]) begin
                next_cur.pmeEnable = cfgWdata[16 + PME_ENABLE_BIT];
            end
            if (cfgByteEn[2] && (cfgWdata[17:16] == PSTATE_D0
                || cfgWdata[17:16] == PSTATE_D3HOT)) begin
                next_cur.pstate = cfgWdata[17:16];
            end
        end
        if (cfgValid && cfgWrite && cfgHitId && cfgByteEn[0]) begin
            next_cur.codecIdCfg = {4'h0, cfgWdata[3:0]};
        end
        case (cur.state)
            IDLE: begin
                if (mixAccept) begin
                    next_cur.codecReq.codecId = range == RANGE_PRIMARY ? PRIMARY_CODEC_ID
                        : range == RANGE_SECONDARY ? cur.codecIdCfg[SEC_ID_LSB +: 2]
                        : cur.codecIdCfg[TER_ID_LSB +: 2];
                    // no byte enables: first word of the eight-byte block
                    next_cur.codecReq.regIndex = {1'h0, mixReq.addr[6:3],
                        mixReq.addr[2] && mixReq.byteEn != 4'h0,
                        wordSel[0]};
                    next_cur.codecReq.write = mixReq.write;
                    next_cur.codecReq.wdata = wHalf;
                    next_cur.wordHigh = wordSel[0];
                    next_cur.state = WAIT;
                end
            end
            WAIT: begin
                if (codecDone) begin
                    next_cur.mixRdata = next_cur.wordHigh ? {codecRdata, 16'h0}
                        : {16'h0, codecRdata};
                    next_cur.state = ANSWER;
                end
            end
            ANSWER: begin
                next_cur.state = IDLE;
            end
            default: begin
                next_cur.state = IDLE;
            end
        endcase
    end

    always_ff @(posedge refClk or negedge rstn) begin
        if (!rstn) begin
            cur <= '{state: IDLE, pstate: PM_CTRL_RESET[1:0], pmeEnable: 1'b0,
                codecIdCfg: CODEC_ID_RESET, mixRdata: 32'h0, wordHigh: 1'b0,
                codecReq: '0};
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge refClk or negedge resumeRstn) begin
        if (!resumeRstn) begin
            pmeStatus <= 1'b0;
        end else begin
            pmeStatus <= next_pmeStatus;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_pme_set;
        @(posedge refClk) disable iff (!resumeRstn) pmeEvent |=> pmeStatus;
    endproperty
    a_pme_set: assert property (p_pme_set) else $error("status not set");

    property p_pme_clr;
        @(posedge refClk) disable iff (!resumeRstn || !rstn)
        (cfgValid && cfgWrite && cfgHitPm && cfgByteEn[3] && cfgWdata[31] && !pmeEvent)
            |=> !pmeStatus;
    endproperty
    a_pme_clr: assert property (p_pme_clr) else $error("status not cleared");

    property p_wake;
        @(posedge refClk) disable iff (!rstn) audio_wake_flag == (pmeStatus && cur.pmeEnable);
    endproperty
    a_wake: assert property (p_wake) else $error("wake flag wrong");

    property p_pstate_legal;
        @(posedge refClk) disable iff (!rstn)
        cur.pstate == PSTATE_D0 || cur.pstate == PSTATE_D3HOT;
    endproperty
    a_pstate_legal: assert property (p_pstate_legal) else $error("bad power state");

    property p_d3_block;
        @(posedge refClk) disable iff (!rstn) inD3 |-> !intOut && !mixAccept;
    endproperty
    a_d3_block: assert property (p_d3_block) else $error("access in D3hot");

    property p_ter_io;
        @(posedge refClk) disable iff (!rstn)
        (mixValid && range == RANGE_TERTIARY && !mixReq.memSpace) |-> !mixAccept;
    endproperty
    a_ter_io: assert property (p_ter_io) else $error("tertiary via I/O");

    property p_sec_id;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == IDLE && mixAccept && range == RANGE_SECONDARY)
            |=> codecReq.codecId == $past(cur.codecIdCfg[1:0]);
    endproperty
    a_sec_id: assert property (p_sec_id) else $error("bad codec id");

    property p_hold;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == WAIT && !codecDone) |=> !mixReady || cur.state == IDLE;
    endproperty
    a_hold: assert property (p_hold) else $error("answered early");

    // ****************************************
    // further checks
    // ****************************************
    property p_pme_keep;
        @(posedge refClk) disable iff (!resumeRstn || !rstn)
        (!pmeEvent && !(cfgValid && cfgWrite && cfgHitPm && cfgByteEn[3] && cfgWdata[31]))
            |=> pmeStatus == $past(pmeStatus);
    endproperty
    a_pme_keep: assert property (p_pme_keep) else $error("status changed");

    property p_pme_out;
        @(posedge refClk) disable iff (!resumeRstn || !rstn) !power_event_out_n |-> pmeStatus;
    endproperty
    a_pme_out: assert property (p_pme_out) else $error("event without status");

    property p_pstate_drop;
        @(posedge refClk) disable iff (!rstn)
        (cfgValid && cfgWrite && cfgHitPm && cfgByteEn[2]
            && (cfgWdata[17:16] == 2'h1 || cfgWdata[17:16] == 2'h2))
            |=> cur.pstate == $past(cur.pstate);
    endproperty
    a_pstate_drop: assert property (p_pstate_drop) else $error("state taken");

    property p_pstate_take;
        @(posedge refClk) disable iff (!rstn)
        (cfgValid && cfgWrite && cfgHitPm && cfgByteEn[2]
            && (cfgWdata[17:16] == PSTATE_D0 || cfgWdata[17:16] == PSTATE_D3HOT))
            |=> cur.pstate == $past(cfgWdata[17:16]);
    endproperty
    a_pstate_take: assert property (p_pstate_take) else $error("state not taken");

    property p_cfg_ready;
        @(posedge refClk) disable iff (!rstn) cfgValid |-> cfgReady;
    endproperty
    a_cfg_ready: assert property (p_cfg_ready) else $error("config not answered");

    property p_range3;
        @(posedge refClk) disable iff (!rstn) (mixValid && range == 2'h3) |-> !mixAccept;
    endproperty
    a_range3: assert property (p_range3) else $error("range above window");

    property p_pri_id;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == IDLE && mixAccept && range == RANGE_PRIMARY)
            |=> codecReq.codecId == PRIMARY_CODEC_ID;
    endproperty
    a_pri_id: assert property (p_pri_id) else $error("bad primary id");

    property p_ter_id;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == IDLE && mixAccept && range == RANGE_TERTIARY)
            |=> codecReq.codecId == $past(cur.codecIdCfg[3:2]);
    endproperty
    a_ter_id: assert property (p_ter_id) else $error("bad tertiary id");

    property p_no_be;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == IDLE && mixAccept && mixReq.byteEn == 4'h0)
            |=> codecReq.regIndex[1:0] == 2'h0;
    endproperty
    a_no_be: assert property (p_no_be) else $error("bad word for no enables");

    property p_low_be;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == IDLE && mixAccept && mixReq.byteEn[1:0] == 2'h0
            && mixReq.byteEn[3:2] != 2'h0) |=> codecReq.regIndex[0];
    endproperty
    a_low_be: assert property (p_low_be) else $error("bad word select");

    property p_wdata_half;
        @(posedge refClk) disable iff (!rstn)
        (cur.state == IDLE && mixAccept && mixReq.write && mixReq.byteEn[1:0] == 2'h0
            && mixReq.byteEn[3:2] != 2'h0) |=> codecReq.wdata == $past(mixReq.wdata[31:16]);
    endproperty
    a_wdata_half: assert property (p_wdata_half) else $error("bad write word");

    property p_one_answer;
        @(posedge refClk) disable iff (!rstn)
        (mixReady && cur.state == ANSWER) |=> !codecValid;
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("codec held after answer");

endmodule : apm_codec_bridge

// ==== verification/apm_codec_model.sv ====
/* codec side model: answers each codec request after dly cycles with one codecDone pulse.
   assumes codecValid holds until the bridge has seen codecDone. */
`timescale 1ns/1ps
module apm_codec_model
    import apm_pkg::*;
(
    input wire logic refClk,
    input wire logic codecValid,
    input wire apm_codec_req_t codecReq,
    input wire logic [3:0] dly,
    output logic codecDone,
    output logic [15:0] codecRdata
);
    // *****
    // codec registers
    // *****
    logic [15:0] regs [0:511];
    initial begin
        codecDone = 1'h0;
        codecRdata = 16'h0000;
        for (int i = 0; i < 512; i++) begin
            regs[i] = 16'hA000 | 16'(i);
        end
    end
    always begin
        @(posedge refClk);
        if (codecValid) begin
            repeat (dly) @(posedge refClk);
            if (codecReq.write) regs[{codecReq.codecId, codecReq.regIndex}] = codecReq.wdata;
            codecDone <= 1'h1;
            codecRdata <= regs[{codecReq.codecId, codecReq.regIndex}];
            @(posedge refClk);
            codecDone <= 1'h0;
            codecRdata <= ~codecRdata;
            while (codecValid) @(posedge refClk);
        end
    end
endmodule : apm_codec_model

// ==== verification/apm_codec_bridge_tb.sv ====
/* bench for apm_codec_bridge: a table of mixer accesses, then power tests.
   assumes apm_codec_model on the codec side. */
`timescale 1ns/1ps
module apm_codec_bridge_tb import apm_pkg::*; ;
    logic refClk = 1'h0, rstn = 1'h0, resumeRstn = 1'h0, cfgValid = 1'h0, cfgWrite = 1'h0;
    logic pmeEvent = 1'h0, intIn = 1'h0, mixValid = 1'h0, d3 = 1'h0, got;
    logic cfgReady, power_event_out_n, audio_wake_flag, intOut, mixReady, codecValid, codecDone;
    logic [7:0] cfgAddr = 8'h00;
    logic [3:0] cfgByteEn = 4'hF, dly = 4'h1, idCfg = 4'h9;
    logic [31:0] cfgWdata = 32'h0, cfgRdata, mixRdata, q;
    logic [15:0] codecRdata;
    logic [15:0] sh [0:511];
    apm_mix_req_t mixReq = '0;
    apm_codec_req_t codecReq, seenReq, e;
    int badCount = 0, checksDone = 0, cyc = 0;
    localparam logic [14:0] ROWS [0:9] = '{{2'h0, 9'h000, 4'hF}, {2'h1, 9'h086, 4'hC},
        {2'h0, 9'h086, 4'h4}, {2'h2, 9'h10C, 4'h8}, {2'h0, 9'h10C, 4'hF}, {2'h0, 9'h03E, 4'h0},
        {2'h3, 9'h0FE, 4'h2}, {2'h2, 9'h0FE, 4'h3}, {2'h2, 9'h180, 4'hF}, {2'h0, 9'h07C, 4'h4}};
    apm_codec_bridge dut (.refClk, .rstn, .resumeRstn, .cfgValid, .cfgWrite, .cfgAddr, .cfgByteEn,
        .cfgWdata, .cfgReady, .cfgRdata, .pmeEvent, .power_event_out_n, .audio_wake_flag, .intIn,
        .intOut, .mixValid, .mixReq, .mixReady, .mixRdata, .codecValid, .codecReq, .codecDone,
        .codecRdata);
    apm_codec_model codec (.refClk, .codecValid, .codecReq, .dly, .codecDone, .codecRdata);
    // *****
    // tasks
    // *****
    task check(input logic [31:0] s, input logic [31:0] x);
        checksDone++;
        if (s !== x) begin
            badCount++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : check
    task summarize;
        if (badCount == 0 && checksDone > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge refClk);
        cfgValid = 1'h1;
        cfgWrite = w;
        cfgAddr = a;
        cfgWdata = d;
        @(posedge refClk);
        q = cfgRdata;
        @(negedge refClk);
        cfgValid = 1'h0;
    endtask : cfg
    task xmix(input logic m, input logic w, input logic [8:0] a, input logic [3:0] be);
        int n;
        logic hi, ok;
        hi = !(be[0] | be[1]) && (be[2] | be[3]);
        ok = a[8:7] != 2'h3 && (a[8:7] != 2'h2 || m) && !d3;
        e = '{a[8:7] == 2'h0 ? PRIMARY_CODEC_ID : a[8:7] == 2'h1 ? idCfg[1:0] : idCfg[3:2],
            {1'h0, a[6:3], a[2] && be != 4'h0, hi}, w, hi ? 16'h1234 : 16'h5678};
        @(negedge refClk);
        mixReq = '{a, be, w, m, 32'h12345678};
        mixValid = 1'h1;
        got = 1'h0;
        n = 0;
        do begin
            @(posedge refClk);
            if (codecValid === 1'h1 && !got) seenReq = codecReq;
            if (codecValid === 1'h1) got = 1'h1;
            n++;
        end while (mixReady !== 1'h1 && n < 40);
        q = mixRdata;
        check(32'(mixReady), 32'h1);
        check(32'(got), 32'(ok));
        if (ok) begin
            if (!w) seenReq.wdata = e.wdata;
            check(32'(seenReq), 32'(e));
            if (!w) check(32'(hi ? q[31:16] : q[15:0]), 32'(sh[{e.codecId, e.regIndex}]));
            if (w) sh[{e.codecId, e.regIndex}] = e.wdata;
        end
        @(negedge refClk);
        mixValid = 1'h0;
    endtask : xmix
    // *****
    // stimulus
    // *****
    initial forever #2.5 refClk = ~refClk;
    always @(posedge refClk) begin
        cyc++;
        if (cyc == 4000) begin
            badCount++;
            summarize();
        end
    end
    initial begin
        for (int i = 0; i < 512; i++) sh[i] = 16'hA000 | 16'(i);
        repeat (3) @(posedge refClk);
        @(negedge refClk);
        rstn = 1'h1;
        resumeRstn = 1'h1;
        cfg(1'h0, PM_CTRL_OFFSET, 32'h0);
        check(32'(q[31:16]), 32'(PM_CTRL_RESET));
        cfg(1'h0, CODEC_ID_OFFSET, 32'h0);
        check(32'(q[3:0]), 32'(CODEC_ID_RESET[3:0]));
        foreach (ROWS[i]) xmix(ROWS[i][14], ROWS[i][13], ROWS[i][12:4], ROWS[i][3:0]);
        dly = 4'h6;
        idCfg = 4'h6;
        cfg(1'h1, CODEC_ID_OFFSET, 32'h6);
        xmix(1'h0, 1'h0, 9'h080, 4'hF);
        xmix(1'h1, 1'h0, 9'h100, 4'hF);
        cfg(1'h1, PM_CTRL_OFFSET, 32'h00030000);
        d3 = 1'h1;
        intIn = 1'h1;
        #1 check(32'(intOut), 32'h0);
        xmix(1'h0, 1'h0, 9'h000, 4'hF);
        cfg(1'h1, PM_CTRL_OFFSET, 32'h00010000);
        cfg(1'h1, PM_CTRL_OFFSET, 32'h00020000);
        cfg(1'h0, PM_CTRL_OFFSET, 32'h0);
        check(32'(q[17:16]), 32'(PSTATE_D3HOT));
        cfg(1'h1, PM_CTRL_OFFSET, 32'h0);
        d3 = 1'h0;
        #1 check(32'(intOut), 32'h1);
        pmeEvent = 1'h1;
        @(negedge refClk);
        pmeEvent = 1'h0;
        cfg(1'h1, PM_CTRL_OFFSET, 32'h01000000);
        cfg(1'h0, PM_CTRL_OFFSET, 32'h0);
        check(32'(q[31:16]), 32'h8100);
        check(32'({audio_wake_flag, power_event_out_n}), 32'h2);
        rstn = 1'h0;
        @(negedge refClk);
        rstn = 1'h1;
        cfg(1'h0, PM_CTRL_OFFSET, 32'h0);
        check(32'(q[31:16]), 32'h8000);
        cfg(1'h1, PM_CTRL_OFFSET, 32'h80000000);
        cfg(1'h0, PM_CTRL_OFFSET, 32'h0);
        check(32'(q[31:16]), 32'h0000);
        summarize();
    end
endmodule : apm_codec_bridge_tb
